// >>> tap_event_detector.sv
// The strobed register port and the placing of the registers were chosen for this implementation.
`include "tap_defines.svh"
module tap_event_detector #(
  parameter int SAMPLE_W  = 16,
  parameter int THS_SHIFT = 4
) (
  // clock, reset, enable
  input  wire logic                    sys_clk,
  input  wire logic                    sys_rst,
  input  wire logic                    clk_en,
  // slope-filtered samples, one strobe per output sample
  input  wire logic                    sample_valid,
  input  wire logic signed [SAMPLE_W-1:0] slope_x,
  input  wire logic signed [SAMPLE_W-1:0] slope_y,
  input  wire logic signed [SAMPLE_W-1:0] slope_z,
  // register port
  input  wire tap_pkg::reg_addr_t      reg_addr,
  input  wire tap_pkg::reg_data_t      reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output tap_pkg::reg_data_t           reg_rdata,
  // interrupt pin
  output logic                         tap_irq
);
  import tap_pkg::*;

  // depth of the pre-peak history; the start and count fields can reach
  // past it, where the check simply stops at the end of the buffer
  localparam int HD = `HIST_DEPTH;

  typedef logic [SAMPLE_W-1:0] mag_t;

  typedef struct packed {
    logic [7:0]            axis_inv;
    logic [7:0]            still_a;
    logic [7:0]            wait_cfg;
    logic [7:0]            latency;
    logic [7:0]            peak;
    logic [7:0]            enable;
    logic [7:0]            preshock;
    logic [7:0]            routing;
    logic [7:0]            mode;
    logic [HD-1:0][SAMPLE_W-1:0] hist;
    // engine state below, configuration and sample history above
    tap_state_t            st;
    logic [7:0]            cnt;
    logic [7:0]            left;
    logic                  neg;
    logic                  rebounded;
    logic [1:0]            taps;
    logic [8:0]            lat;
    logic [3:0]            flags;
    logic [7:0]            rdata;
    logic                  irq;
  } state_t;

  state_t s;
  state_t next_s;

  // magnitude of a signed sample; the most negative value still fits unsigned
  function automatic mag_t magnitude(input logic signed [SAMPLE_W-1:0] v);
    magnitude = v[SAMPLE_W-1] ? mag_t'(-v) : mag_t'(v);
  endfunction

  // threshold code scaled onto the sample lsb grid
  function automatic mag_t scale_ths(input logic [5:0] t);
    scale_ths = mag_t'(mag_t'(t) << THS_SHIFT);
  endfunction

  // a phase counter is done when the sample now seen is its last one;
  // counting from zero keeps every phase a single compare
  function automatic logic count_done(input logic [7:0] c, input logic [7:0] len);
    count_done = (8'(c + 8'h01) >= len);
  endfunction

  // every selected history sample below the pre-shock threshold
  // the end index is one bit wider, so a start plus count above the depth,
  // which software must avoid, simply stops at the end of the buffer
  function automatic logic pre_quiet(input logic [HD-1:0][SAMPLE_W-1:0] h,
                                     input logic [3:0] start,
                                     input logic [3:0] num,
                                     input mag_t thr);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < HD; i++) begin
      if ((5'(i) >= {1'b0, start}) && (5'(i) < 5'({1'b0, start} + {1'b0, num})) &&
          !(h[i] < thr)) begin
        ok = 1'b0;
      end
    end
    pre_quiet = ok;
  endfunction

  // register read mux
  function automatic logic [7:0] read_mux(input state_t c, input reg_addr_t a);
    logic [7:0] d;
    d = 8'h00;
    case (a)
      `ADDR_AXIS_INV: d = c.axis_inv;
      `ADDR_STILL_A:  d = c.still_a;
      `ADDR_WAIT:     d = c.wait_cfg;
      `ADDR_LATENCY:  d = c.latency;
      `ADDR_PEAK:     d = c.peak;
      `ADDR_ENABLE:   d = c.enable;
      `ADDR_PRESHOCK: d = c.preshock;
      `ADDR_STATUS:   d = {4'h0, c.flags};
      `ADDR_ROUTING:  d = c.routing;
      `ADDR_ALL_SRC:  d = {4'h0, c.flags[`B_ANY], 3'h0};
      `ADDR_MODE:     d = c.mode;
      default:        d = 8'h00;
    endcase
    read_mux = d;
  endfunction

  // next-state logic for the whole block
  always_comb begin
    mag_t       mag;
    logic       sgn;
    logic       run;
    logic       go_wait;
    logic       go_post;
    logic       tap_now;
    logic       expire;
    logic [1:0] top;
    logic [1:0] nt;
    logic [1:0] emit;
    logic [7:0] invt;
    logic [7:0] wait_len;
    logic [7:0] post_len;
    logic [7:0] reb_len;
    logic [8:0] lat_len;
    logic [3:0] clr;
    mag      = '0;
    sgn      = 1'b0;
    go_wait  = 1'b0;
    go_post  = 1'b0;
    tap_now  = 1'b0;
    expire   = 1'b0;
    nt       = 2'd0;
    emit     = 2'd0; // tap level to flag this sample, zero for none
    clr      = 4'h0;
    next_s   = s;
    run      = s.enable[`B_SINGLE_EN] && (s.axis_inv[`F_AXIS] != 2'b00);
    invt     = {3'h0, s.axis_inv[`F_INVERT]};
    wait_len = {1'b0, s.wait_cfg[`F_WAIT], 1'b0};
    post_len = {s.wait_cfg[`F_POST_HI], s.still_a[`F_POST_LO], 2'b00};
    reb_len  = {2'b00, s.enable[`F_REBOUND], 1'b0};
    lat_len  = (s.latency[`F_LATENCY] == 4'h0) ? `LAT_MIN :
               {s.latency[`F_LATENCY], 5'h00};
    // highest enabled tap level, closes a multi-tap early
    top      = s.enable[`B_TRIPLE_EN] ? 2'd3 :
               (s.enable[`B_DOUBLE_EN] ? 2'd2 : 2'd1);

    // register writes; status registers are read only
    // writes to status places and unmapped addresses fall through unchanged
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_AXIS_INV: next_s.axis_inv = reg_wdata;
        `ADDR_STILL_A:  next_s.still_a  = reg_wdata;
        `ADDR_WAIT:     next_s.wait_cfg = reg_wdata;
        `ADDR_LATENCY:  next_s.latency  = reg_wdata;
        `ADDR_PEAK:     next_s.peak     = reg_wdata;
        `ADDR_ENABLE:   next_s.enable   = reg_wdata;
        `ADDR_PRESHOCK: next_s.preshock = reg_wdata;
        `ADDR_ROUTING:  next_s.routing  = reg_wdata;
        `ADDR_MODE:     next_s.mode     = reg_wdata;
        default:        next_s.mode     = s.mode;
      endcase
    end

    // read data stand one cycle only, zero otherwise
    next_s.rdata = reg_rd ? read_mux(s, reg_addr) : 8'h00;
    // either source register clears on read; a set in the same cycle still wins
    if (reg_rd && ((reg_addr == `ADDR_STATUS) || (reg_addr == `ADDR_ALL_SRC))) begin
      clr = 4'hf;
    end

    if (sample_valid) begin
      // pick the axis; nothing else feeds the engine
      // axis 00 feeds zeros, which also keeps the history quiet
      unique case (s.axis_inv[`F_AXIS])
        2'b01: begin
          mag = magnitude(slope_x);
          sgn = slope_x[SAMPLE_W-1];
        end
        2'b10: begin
          mag = magnitude(slope_y);
          sgn = slope_y[SAMPLE_W-1];
        end
        2'b11: begin
          mag = magnitude(slope_z);
          sgn = slope_z[SAMPLE_W-1];
        end
        2'b00: begin
          mag = '0;
          sgn = 1'b0;
        end
      endcase

      // level mode: a flag lasts exactly one sample period
      if (!s.mode[`B_LATCHED]) begin
        clr = 4'hf;
      end

      // history slides every sample; index 0 is the oldest
      // it keeps sliding in every state so the next tap sees fresh samples
      for (int i = 0; i < HD - 1; i++) begin
        next_s.hist[i] = s.hist[i+1];
      end
      next_s.hist[HD-1] = mag;

      if (run) begin
        unique case (s.st)
          ST_IDLE: begin
            // a peak failing the pre-shock check is dropped; the next may start anew
            if (mag > scale_ths(s.peak[`F_PEAK])) begin
              // count of zero leaves the check always true
              if (pre_quiet(s.hist, s.preshock[`F_PRE_START], s.preshock[`F_PRE_COUNT],
                            scale_ths({2'b00, s.still_a[`F_PRE_THS]}))) begin
                next_s.neg = sgn;
                if (invt == 8'h00) begin
                  go_wait = 1'b1;
                end else begin
                  next_s.st  = ST_INVERT;
                  next_s.cnt = 8'h00;
                end
              end
            end
          end
          ST_INVERT: begin
            // same-sign loud samples still belong to the first peak
            if ((mag > scale_ths(s.peak[`F_PEAK])) && (sgn != s.neg)) begin
              go_wait = 1'b1;
            end else if (count_done(s.cnt, invt)) begin
              next_s.st = ST_IDLE;
            end else begin
              next_s.cnt = s.cnt + 8'h01;
            end
          end
          ST_WAIT: begin
            // samples during the wait are not judged at all
            if (count_done(s.cnt, wait_len)) begin
              go_post = 1'b1;
            end else begin
              next_s.cnt = s.cnt + 8'h01;
            end
          end
          ST_POST: begin
            // left counts the quiet samples the window still owes
            if (mag < scale_ths({2'b00, s.latency[`F_POST_THS]})) begin
              if (s.left == 8'h01) begin
                tap_now   = 1'b1;
                next_s.st = ST_IDLE;
              end else begin
                next_s.left = s.left - 8'h01;
              end
            end else if ((reb_len != 8'h00) && !s.rebounded) begin
              // left keeps window minus samples already verified
              next_s.st        = ST_REBOUND;
              next_s.cnt       = 8'h00;
              next_s.rebounded = 1'b1;
            end else begin
              next_s.st = ST_IDLE;
            end
          end
          ST_REBOUND: begin
            // the rebound itself is not judged, only its length counts
            if (count_done(s.cnt, reb_len)) begin
              next_s.st = ST_POST;
            end else begin
              next_s.cnt = s.cnt + 8'h01;
            end
          end
        endcase

        // shared entry into the wait and quiet phases
        if (go_wait) begin
          if (wait_len == 8'h00) begin
            go_post = 1'b1;
          end else begin
            next_s.st  = ST_WAIT;
            next_s.cnt = 8'h00;
          end
        end
        // rebound credit is restored for each new quiet window
        if (go_post) begin
          next_s.rebounded = 1'b0;
          if (post_len == 8'h00) begin
            tap_now   = 1'b1;
            next_s.st = ST_IDLE;
          end else begin
            next_s.st   = ST_POST;
            next_s.left = post_len;
          end
        end

        // latency window between taps of a multi-tap
        // each tap restarts it, so the gap is measured tap to tap
        if (s.taps != 2'd0) begin
          if ((s.lat + 9'h001) >= lat_len) begin
            expire = 1'b1;
          end else begin
            next_s.lat = s.lat + 9'h001;
          end
        end
        // the top level closes the sequence at once; lower levels open the window
        if (tap_now) begin
          nt = 2'(s.taps + 2'd1);
          if (!s.peak[`B_WAIT_END]) begin
            emit = nt;
          end
          if (nt == top) begin
            if (s.peak[`B_WAIT_END]) begin
              emit = nt;
            end
            next_s.taps = 2'd0;
          end else begin
            next_s.taps = nt;
            next_s.lat  = 9'h000;
          end
        end else if (expire) begin
          if (s.peak[`B_WAIT_END]) begin
            emit = s.taps;
          end
          next_s.taps = 2'd0;
        end
      end else begin
        // engine off: drop any half-seen tap
        next_s.st   = ST_IDLE;
        next_s.taps = 2'd0;
      end
    end

    // clears first, then sets, so an event in a read cycle is kept
    // a type flag rises only when that type is enabled; the common flag with it
    next_s.flags = s.flags & ~clr;
    case (emit)
      2'd1: if (s.enable[`B_SINGLE_EN]) begin
        next_s.flags[`B_ONE] = 1'b1;
        next_s.flags[`B_ANY] = 1'b1;
      end
      2'd2: if (s.enable[`B_DOUBLE_EN]) begin
        next_s.flags[`B_TWO] = 1'b1;
        next_s.flags[`B_ANY] = 1'b1;
      end
      2'd3: if (s.enable[`B_TRIPLE_EN]) begin
        next_s.flags[`B_THREE] = 1'b1;
        next_s.flags[`B_ANY]   = 1'b1;
      end
      default: next_s.flags[`B_ANY] = next_s.flags[`B_ANY];
    endcase

    // pin follows the common flag through its routing bit
    next_s.irq = next_s.flags[`B_ANY] & s.routing[`B_ROUTE_TAP];
  end

  // all state in one register
  // clk_en low freezes everything, read data and pin included
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s          <= '0;
      s.axis_inv <= `REG_RESET;
      s.st       <= ST_IDLE;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  // both outputs come straight from the state register
  assign reg_rdata = s.rdata;
  assign tap_irq   = s.irq;

endmodule // tap_event_detector

// >>> tap_defines.svh
`ifndef TAP_DEFINES_SVH
`define TAP_DEFINES_SVH
`define ADDR_AXIS_INV   4'h0
`define ADDR_STILL_A    4'h1
`define ADDR_WAIT       4'h2
`define ADDR_LATENCY    4'h3
`define ADDR_PEAK       4'h4
`define ADDR_ENABLE     4'h5
`define ADDR_PRESHOCK   4'h6
`define ADDR_STATUS     4'h7
`define ADDR_ROUTING    4'h8
`define ADDR_ALL_SRC    4'h9
`define ADDR_MODE       4'ha
`define F_AXIS          7:6
`define F_INVERT        5:1
`define F_PRE_THS       7:4
`define F_POST_LO       3:0
`define F_POST_HI       7:6
`define F_WAIT          5:0
`define F_POST_THS      7:4
`define F_LATENCY       3:0
`define B_WAIT_END      7
`define F_PEAK          5:0
`define B_TRIPLE_EN     7
`define B_DOUBLE_EN     6
`define B_SINGLE_EN     5
`define F_REBOUND       4:0
`define F_PRE_START     7:4
`define F_PRE_COUNT     3:0
`define B_ROUTE_TAP     3
`define B_LATCHED       0
`define B_ONE           0
`define B_TWO           1
`define B_THREE         2
`define B_ANY           3
`define HIST_DEPTH      14
`define LAT_MIN         9'h010
`define REG_RESET       8'h00
`endif

// >>> tap_pkg.sv
package tap_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] reg_data_t;
  typedef enum logic [4:0] {
    ST_IDLE    = 5'b00001,
    ST_INVERT  = 5'b00010,
    ST_WAIT    = 5'b00100,
    ST_POST    = 5'b01000,
    ST_REBOUND = 5'b10000
  } tap_state_t;
endpackage

// >>> tap_event_checker.sv
`include "tap_defines.svh"
module tap_event_checker (
  // clock, reset and enable
  input wire logic               sys_clk,
  input wire logic               sys_rst,
  input wire logic               clk_en,
  // samples and register port
  input wire logic               sample_valid,
  input wire tap_pkg::reg_addr_t reg_addr,
  input wire tap_pkg::reg_data_t reg_wdata,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire tap_pkg::reg_data_t reg_rdata,
  // interrupt pin
  input wire logic               tap_irq
);
  import tap_pkg::*;
  typedef struct packed {
    logic [1:0] axis;
    logic       single;
    logic       route;
    logic       route_d;
    logic       latched;
  } shadow_t;
  shadow_t sh;
  shadow_t next_sh;
  logic    eng_on;
  // shadow of the config bits that gate the pin; route_d covers the pin's register stage
  always_comb begin
    next_sh = sh;
    next_sh.route_d = sh.route;
    if (reg_wr && clk_en) begin
      if (reg_addr == `ADDR_AXIS_INV) next_sh.axis = reg_wdata[`F_AXIS];
      if (reg_addr == `ADDR_ENABLE) next_sh.single = reg_wdata[`B_SINGLE_EN];
      if (reg_addr == `ADDR_ROUTING) next_sh.route = reg_wdata[`B_ROUTE_TAP];
      if (reg_addr == `ADDR_MODE) next_sh.latched = reg_wdata[`B_LATCHED];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) sh <= '0;
    else sh <= next_sh;
  end
  assign eng_on = (sh.axis != 2'b00) && sh.single;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // a clearing read with no sample landing in the same cycle
  sequence rd_src;
    reg_rd && clk_en && !sample_valid
      && (reg_addr == `ADDR_STATUS || reg_addr == `ADDR_ALL_SRC);
  endsequence
  chk_status_format: assert property (
    $past(reg_rd) && $past(reg_addr) == `ADDR_STATUS
      |-> reg_rdata[7:4] == 4'h0 && reg_rdata[3] == (reg_rdata[2:0] != 3'h0))
    else $error("status read has a bad flag pattern");
  chk_irq_rise_cause: assert property (
    $rose(tap_irq) |-> $past(sample_valid) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt rose without a sample");
  chk_irq_fall_cause: assert property (
    $fell(tap_irq) |-> $past(sample_valid) || $past(reg_rd) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("interrupt fell without a cause");
  chk_read_clears: assert property (
    rd_src |=> !tap_irq)
    else $error("interrupt kept after a clearing read");
  chk_latch_holds: assert property (
    tap_irq && sh.latched && sh.route && sh.route_d && clk_en && !reg_rd && !reg_wr
      |=> tap_irq)
    else $error("latched interrupt dropped without a read");
  chk_level_drop: assert property (
    tap_irq && !sh.latched && sample_valid && clk_en |=> !tap_irq)
    else $error("level interrupt held past one sample");
  chk_engine_off: assert property (
    sample_valid && clk_en && !eng_on |=> !$rose(tap_irq))
    else $error("tap flagged while the engine is off");
  chk_route_off: assert property (
    !sh.route && !sh.route_d |-> !tap_irq)
    else $error("interrupt driven while not routed");
endmodule // tap_event_checker

bind tap_event_detector tap_event_checker u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .sample_valid(sample_valid),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tap_irq(tap_irq)
);

// >>> odr_source.sv
module odr_source #(
  parameter int DIV = 4
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               sys_rst,
  // level wanted on the tap axis
  input  wire logic signed [15:0] z_level,
  // sample stream
  output logic                    sample_valid,
  output logic signed [15:0]      slope_x,
  output logic signed [15:0]      slope_y,
  output logic signed [15:0]      slope_z
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  int seed = 32'hc7610c83;
  initial {sample_valid, slope_x, slope_y, slope_z} = '0;
  // one sample every DIV clocks, a fast output rate so a tap fits a short run
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      cnt <= 0;
      sample_valid <= 1'b0;
    end else begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      sample_valid <= (cnt == DIV - 1);
    end
    // other axes and idle cycles carry loud noise, never a stale value
    slope_x <= 16'($random(seed));
    slope_y <= 16'($random(seed));
    slope_z <= (cnt == DIV - 1) ? z_level : 16'($random(seed));
  end
endmodule // odr_source

// >>> testbench.sv
`include "tap_defines.svh"
`define CHK(got, exp, msg) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("CHECK FAILED at %0t: %s", $time, msg); \
  end \
end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import tap_pkg::*;
  logic               sys_clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               clk_en = 1'b1;
  logic               sample_valid;
  logic signed [15:0] slope_x, slope_y, slope_z;
  logic signed [15:0] z_level = 16'sh0000;
  reg_addr_t          reg_addr = 4'h0;
  reg_data_t          reg_wdata = 8'h00;
  logic               reg_wr = 1'b0;
  logic               reg_rd = 1'b0;
  reg_data_t          reg_rdata;
  logic               tap_irq;
  int                 miscompares = 0;
  int                 samples_checked = 0;
  int                 seed = 32'hc7610c83;
  reg_data_t          cfg [11] = '{8'hc8, 8'h21, 8'h00, 8'h40, 8'h08, 8'h20, 8'h0a,
                                   8'h00, 8'h08, 8'h00, 8'h00};
  initial forever #25 sys_clk = ~sys_clk;
  tap_event_detector u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .sample_valid(sample_valid),
    .slope_x(slope_x), .slope_y(slope_y), .slope_z(slope_z), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tap_irq(tap_irq)
  );
  odr_source u_src (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .z_level(z_level), .sample_valid(sample_valid),
    .slope_x(slope_x), .slope_y(slope_y), .slope_z(slope_z)
  );
  // bits the test writes to each register; status, all-source and unmapped places read zero
  function automatic reg_data_t rw_mask(input int a);
    case (a)
      0: return 8'hfe;
      4: return 8'hbf;
      8: return 8'h08;
      10: return 8'h01;
      1, 2, 3, 5, 6: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input reg_addr_t a, input reg_data_t e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    `CHK(reg_rdata, e, "register read")
  endtask
  // value is taken at the tick after the one waited for, so a call ends where the last lands
  task automatic put(input logic signed [15:0] v);
    @(posedge sys_clk iff sample_valid);
    z_level <= v;
  endtask
  task automatic run_tap(input int npre, input logic signed [15:0] pre_v, input bit inv_ok,
                         input logic signed [15:0] post_v, input logic exp_irq);
    logic signed [15:0] pk;
    pk = 16'sd129 + 16'($random(seed) & 32'h1ff);
    if ($random(seed) & 1) pk = -pk;
    for (int i = 0; i < npre; i++) put(i == 2 ? pre_v : 16'sh0000);
    put(pk);
    put(inv_ok ? -pk : pk);
    for (int i = 0; i < 4; i++) put(i == 1 ? post_v : 16'sh0000);
    put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, exp_irq, "pin after tap sequence")
  endtask
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard at 10000 clocks, far beyond the roughly 1200 clocks the tests need
  initial begin
    #500000;
    miscompares++;
    stop_test();
  end
  initial begin
    reg_data_t d;
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // downwards, so the engine is armed only after status has been read
    for (int a = 11; a >= 0; a--) begin
      d = 8'($random(seed));
      if (rw_mask(a) != 8'h00) d = d & rw_mask(a);
      rd(reg_addr_t'(a), 8'h00);
      wr(reg_addr_t'(a), d);
      rd(reg_addr_t'(a), d & rw_mask(a));
    end
    for (int a = 0; a < 11; a++) wr(reg_addr_t'(a), cfg[a]);
    $display("registers done");
    run_tap(14, 16'sh0000, 1'b1, 16'sh0000, 1'b1);
    rd(`ADDR_STATUS, 8'h09);
    run_tap(14, 16'sh0000, 1'b1, 16'sh0000, 1'b1);
    put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, 1'b0, "level pin after one sample")
    rd(`ADDR_STATUS, 8'h00);
    run_tap(14, 16'sd50, 1'b1, 16'sh0000, 1'b0);
    run_tap(14, 16'sh0000, 1'b0, 16'sh0000, 1'b0);
    run_tap(14, 16'sh0000, 1'b1, 16'sd100, 1'b0);
    $display("single taps done");
    wr(`ADDR_AXIS_INV, 8'h08);
    run_tap(14, 16'sh0000, 1'b1, 16'sh0000, 1'b0);
    wr(`ADDR_AXIS_INV, 8'hc8);
    wr(`ADDR_ENABLE, 8'h00);
    run_tap(14, 16'sh0000, 1'b1, 16'sh0000, 1'b0);
    wr(`ADDR_ENABLE, 8'h20);
    wr(`ADDR_ROUTING, 8'h00);
    run_tap(14, 16'sh0000, 1'b1, 16'sh0000, 1'b0);
    rd(`ADDR_STATUS, 8'h09);
    wr(`ADDR_ROUTING, 8'h08);
    $display("gating done");
    wr(`ADDR_MODE, 8'h01);
    run_tap(14, 16'sh0000, 1'b1, 16'sh0000, 1'b1);
    put(16'sh0000);
    put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, 1'b1, "latched pin held")
    rd(`ADDR_ALL_SRC, 8'h08);
    `CHK(tap_irq, 1'b0, "latched pin after read")
    wr(`ADDR_MODE, 8'h00);
    $display("latched done");
    // pre-shock check off so the second tap can follow inside the shortest latency
    wr(`ADDR_ENABLE, 8'h60);
    wr(`ADDR_PRESHOCK, 8'h00);
    run_tap(2, 16'sh0000, 1'b1, 16'sh0000, 1'b1);
    rd(`ADDR_STATUS, 8'h09);
    run_tap(2, 16'sh0000, 1'b1, 16'sh0000, 1'b1);
    rd(`ADDR_STATUS, 8'h0a);
    $display("double tap done");
    // one rebound of 2 samples, then only the 3 unverified quiet samples
    wr(`ADDR_ENABLE, 8'h21);
    run_tap(2, 16'sh0000, 1'b1, 16'sd100, 1'b0);
    repeat (3) put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, 1'b1, "pin after rebound")
    rd(`ADDR_STATUS, 8'h09);
    run_tap(2, 16'sh0000, 1'b1, 16'sd100, 1'b0);
    put(16'sd100);
    repeat (5) put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, 1'b0, "second rebound rejects")
    $display("rebound done");
    // wait for latency end: a lone tap flags only after 16 samples
    wr(`ADDR_ENABLE, 8'h60);
    wr(`ADDR_PEAK, 8'h88);
    run_tap(2, 16'sh0000, 1'b1, 16'sh0000, 1'b0);
    repeat (15) put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, 1'b0, "no flag inside latency")
    put(16'sh0000);
    @(negedge sys_clk);
    `CHK(tap_irq, 1'b1, "flag at latency end")
    rd(`ADDR_STATUS, 8'h09);
    $display("latency end done");
    stop_test();
  end
endmodule // testbench
